// >>> pcr_pkg.sv
// Constants shared by the configuration header register bank
package pcr_pkg;

   localparam int          PCR_ADDR_W    = 9;

   // Byte offsets within the controller's register window
   localparam logic [8:0]  PCR_OFS_ID    = 9'h100;
   localparam logic [8:0]  PCR_OFS_PART  = 9'h102;
   localparam logic [8:0]  PCR_OFS_CMD   = 9'h104;
   localparam logic [8:0]  PCR_OFS_STS   = 9'h106;

   // Command word bit positions
   localparam int          PCR_CMD_IO    = 0;
   localparam int          PCR_CMD_MEM   = 1;
   localparam int          PCR_CMD_BM    = 2;
   localparam int          PCR_CMD_PER   = 6;
   localparam int          PCR_CMD_SERR  = 8;
   localparam logic [15:0] PCR_CMD_WMASK = 16'h0147;
   localparam logic [15:0] PCR_CMD_RST   = 16'h0000;

   // Status word bit positions, counted within the 16-bit status half
   localparam int          PCR_STS_DPR   = 8;
   localparam int          PCR_STS_STA   = 11;
   localparam int          PCR_STS_RTA   = 12;
   localparam int          PCR_STS_RMA   = 13;
   localparam int          PCR_STS_SSE   = 14;
   localparam int          PCR_STS_DPE   = 15;
   localparam logic [15:0] PCR_STS_FLAGS = 16'hF900;
   localparam logic [15:0] PCR_STS_CONST = 16'h0280;
   localparam logic [15:0] PCR_STS_HARD  = 16'h06FF;

   // Least CPU clocks between a register change and a bus access
   localparam int          PCR_SETTLE_CLKS = 2;

endpackage : pcr_pkg

// >>> pcr_regs.sv
// Host-bridge configuration header registers: identifiers, command, status
`timescale 1ns/10ps
module pcr_regs
   import pcr_pkg::*;
#(
   // Arbitrary identity values, not those of any real part
   parameter logic [15:0] MAKER_ID = 16'hA5C3,
   parameter logic [15:0] PART_ID  = 16'h0042
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              cpu_sel,
   input  wire logic              cpu_wr,
   input  wire logic [8:0]        cpu_addr,
   input  wire logic [3:0]        cpu_be,
   input  wire logic [31:0]       cpu_wdata,
   output logic                   cpu_ack,
   output logic [31:0]            cpu_rdata,
   input  wire logic              ev_sig_target_abort,
   input  wire logic              ev_rcv_target_abort,
   input  wire logic              ev_rcv_master_abort,
   input  wire logic              ev_parity_error,
   input  wire logic              ev_data_parity,
   input  wire logic              perr_req,
   input  wire logic              serr_req,
   input  wire logic              mem_access_req,
   input  wire logic              master_req,
   output logic                   io_space_enable,
   output logic                   memory_space_enable,
   output logic                   bus_master_enable,
   output logic                   parity_check_enable,
   output logic                   system_error_drive_enable,
   output logic                   perr_drive,
   output logic                   serr_drive,
   output logic                   mem_respond,
   output logic                   master_go,
   output logic                   pci_access_ok
);

   typedef struct packed
   {
      logic        ack;
      logic [31:0] rdata;
      logic [15:0] cmd;
      logic [15:0] sts;
      logic        perr;
      logic        serr;
      logic        mem;
      logic        mst;
   } pcr_state_t;

   localparam pcr_state_t S_RST = '{
      ack:   1'b0,
      rdata: 32'h0000_0000,
      cmd:   PCR_CMD_RST,
      sts:   PCR_STS_CONST,
      perr:  1'b0,
      serr:  1'b0,
      mem:   1'b0,
      mst:   1'b0
   };

   pcr_state_t s_q;
   pcr_state_t s_d;

   logic        hit_id;
   logic        hit_cs;
   logic        wr_cs;
   logic [15:0] cmd_m;
   logic [15:0] sts_clr;
   logic [15:0] sts_set;

   // Word match on the aligned 32-bit word holding a printed offset
   function automatic logic word_hit(input logic [8:0] a, input logic [8:0] ofs);
      return a[8:2] == ofs[8:2];
   endfunction : word_hit

   // Two byte enables widened to a 16-bit lane mask
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   assign hit_id = word_hit(cpu_addr, PCR_OFS_ID);
   assign hit_cs = word_hit(cpu_addr, PCR_OFS_CMD);
   assign wr_cs  = cpu_sel && cpu_wr && hit_cs;

   // Only writable command bits pass; hardwired bits never move
   assign cmd_m  = lane_mask(cpu_be[1:0]) & PCR_CMD_WMASK;

   // Clear mask limited to flag bits; constants are out of reach
   assign sts_clr = wr_cs ? (cpu_wdata[31:16] & lane_mask(cpu_be[3:2]) & PCR_STS_FLAGS)
                          : 16'h0000;

   always_comb
   begin
      sts_set = 16'h0000;
      sts_set[PCR_STS_STA] = ev_sig_target_abort;
      sts_set[PCR_STS_RTA] = ev_rcv_target_abort;
      sts_set[PCR_STS_RMA] = ev_rcv_master_abort;
      sts_set[PCR_STS_SSE] = serr_req && s_q.cmd[PCR_CMD_SERR];
      sts_set[PCR_STS_DPE] = ev_parity_error;
      sts_set[PCR_STS_DPR] = ev_data_parity && s_q.cmd[PCR_CMD_PER];
   end

   always_comb
   begin
      s_d       = s_q;
      s_d.ack   = cpu_sel;
      s_d.rdata = 32'h0000_0000;
      if (cpu_sel && !cpu_wr)
      begin
         if (hit_id)
         begin
            s_d.rdata = {PART_ID, MAKER_ID};
         end
         else if (hit_cs)
         begin
            // Hardwired status fields are forced, not stored
            s_d.rdata = {(s_q.sts & ~PCR_STS_HARD) | PCR_STS_CONST,
                         s_q.cmd & PCR_CMD_WMASK};
         end
         else
         begin
            s_d.rdata = 32'h0000_0000;
         end
      end
      if (wr_cs)
      begin
         s_d.cmd = (s_q.cmd & ~cmd_m) | (cpu_wdata[15:0] & cmd_m);
      end
      // A set in the same cycle as its clear wins
      s_d.sts  = (s_q.sts & ~sts_clr) | sts_set;
      s_d.perr = perr_req && s_q.cmd[PCR_CMD_PER];
      s_d.serr = serr_req && s_q.cmd[PCR_CMD_SERR];
      // Special cycles carry no request here, so they reach nothing
      s_d.mem  = mem_access_req && s_q.cmd[PCR_CMD_MEM];
      s_d.mst  = master_req && s_q.cmd[PCR_CMD_BM];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= S_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Hold-off after any CPU write to the command/status word
   pcr_settle #(
      .CLKS (PCR_SETTLE_CLKS)
   ) u_settle (
      .clk   (clk),
      .rst   (rst),
      .kick  (wr_cs),
      .ready (pci_access_ok)
   );

   assign cpu_ack                   = s_q.ack;
   assign cpu_rdata                 = s_q.rdata;
   assign io_space_enable           = s_q.cmd[PCR_CMD_IO];
   assign memory_space_enable       = s_q.cmd[PCR_CMD_MEM];
   assign bus_master_enable         = s_q.cmd[PCR_CMD_BM];
   assign parity_check_enable       = s_q.cmd[PCR_CMD_PER];
   assign system_error_drive_enable = s_q.cmd[PCR_CMD_SERR];
   assign perr_drive                = s_q.perr;
   assign serr_drive                = s_q.serr;
   assign mem_respond               = s_q.mem;
   assign master_go                 = s_q.mst;

   chk_flag_clear:
   assert property (@(posedge clk) disable iff (rst)
      (wr_cs && cpu_be[3] && cpu_wdata[31] && !ev_parity_error)
      |=> !s_q.sts[PCR_STS_DPE])
   else $error("parity flag not cleared by write of one");

   chk_flag_keep:
   assert property (@(posedge clk) disable iff (rst)
      (s_q.sts[PCR_STS_STA] && !(wr_cs && cpu_be[3] && cpu_wdata[27]))
      |=> s_q.sts[PCR_STS_STA])
   else $error("signaled abort flag lost without a clear");

   chk_maker_code:
   assert property (@(posedge clk) disable iff (rst)
      (cpu_sel && !cpu_wr && hit_id) |=> (cpu_ack && cpu_rdata[15:0] == MAKER_ID))
   else $error("maker identifier read wrong");

   chk_part_code:
   assert property (@(posedge clk) disable iff (rst)
      (cpu_sel && !cpu_wr && hit_id) |=> (cpu_rdata[31:16] == PART_ID))
   else $error("part identifier read wrong");

   chk_io_write:
   assert property (@(posedge clk) disable iff (rst)
      (wr_cs && cpu_be[0]) |=> (io_space_enable == $past(cpu_wdata[0])))
   else $error("io space enable did not take write");

   chk_mem_gate:
   assert property (@(posedge clk) disable iff (rst)
      mem_respond |-> $past(mem_access_req && memory_space_enable))
   else $error("memory response while disabled");

   chk_mem_follow:
   assert property (@(posedge clk) disable iff (rst)
      (mem_access_req && memory_space_enable) |=> mem_respond)
   else $error("enabled memory access got no response");

   chk_master_gate:
   assert property (@(posedge clk) disable iff (rst)
      master_go |-> $past(master_req && bus_master_enable))
   else $error("master access while disabled");

   chk_master_follow:
   assert property (@(posedge clk) disable iff (rst)
      (master_req && bus_master_enable) |=> master_go)
   else $error("enabled master request not passed on");

   chk_cmd_consts:
   assert property (@(posedge clk) disable iff (rst)
      (cpu_sel && !cpu_wr && hit_cs)
      |=> ((cpu_rdata[15:0] & ~PCR_CMD_WMASK) == 16'h0000))
   else $error("hardwired command bit read nonzero");

   chk_perr_gate:
   assert property (@(posedge clk) disable iff (rst)
      perr_req ##1 1'b1 |-> (perr_drive == $past(parity_check_enable)))
   else $error("parity line not gated by enable");

   chk_dpr_gate:
   assert property (@(posedge clk) disable iff (rst)
      (ev_data_parity && parity_check_enable) |=> s_q.sts[PCR_STS_DPR])
   else $error("reported parity flag not set while enabled");

   chk_dpr_off:
   assert property (@(posedge clk) disable iff (rst)
      (ev_data_parity && !parity_check_enable && !s_q.sts[PCR_STS_DPR])
      |=> !s_q.sts[PCR_STS_DPR])
   else $error("reported parity flag set while disabled");

   chk_dpr_clear:
   assert property (@(posedge clk) disable iff (rst)
      (wr_cs && cpu_be[3] && cpu_wdata[24] && !ev_data_parity)
      |=> !s_q.sts[PCR_STS_DPR])
   else $error("reported parity flag not cleared by write of one");

   chk_serr_gate:
   assert property (@(posedge clk) disable iff (rst)
      serr_drive |-> $past(system_error_drive_enable))
   else $error("system error line driven while disabled");

   chk_serr_follow:
   assert property (@(posedge clk) disable iff (rst)
      (serr_req && system_error_drive_enable) |=> serr_drive)
   else $error("enabled system error request not driven");

   chk_sts_consts:
   assert property (@(posedge clk) disable iff (rst)
      (cpu_sel && !cpu_wr && hit_cs)
      |=> ((cpu_rdata[31:16] & PCR_STS_HARD) == PCR_STS_CONST))
   else $error("hardwired status field read wrong");

   chk_sta_set:
   assert property (@(posedge clk) disable iff (rst)
      ev_sig_target_abort |=> s_q.sts[PCR_STS_STA])
   else $error("signaled abort flag not set by event");

   chk_rta_set:
   assert property (@(posedge clk) disable iff (rst)
      ev_rcv_target_abort |=> s_q.sts[PCR_STS_RTA])
   else $error("received target abort flag not set");

   chk_rma_set:
   assert property (@(posedge clk) disable iff (rst)
      ev_rcv_master_abort |=> s_q.sts[PCR_STS_RMA])
   else $error("received master abort flag not set");

   chk_rma_keep:
   assert property (@(posedge clk) disable iff (rst)
      (s_q.sts[PCR_STS_RMA] && !(wr_cs && cpu_be[3] && cpu_wdata[29]))
      |=> s_q.sts[PCR_STS_RMA])
   else $error("master abort flag lost without a clear");

   // Software may only drop flags; every rising bit needs a hardware event
   chk_flag_origin:
   assert property (@(posedge clk) disable iff (rst)
      ((s_q.sts & ~$past(s_q.sts) & ~$past(sts_set)) == 16'h0000))
   else $error("status flag rose without a hardware event");

   chk_sse_set:
   assert property (@(posedge clk) disable iff (rst)
      (serr_req && system_error_drive_enable) |=> s_q.sts[PCR_STS_SSE])
   else $error("system error flag not set");

   chk_sse_off:
   assert property (@(posedge clk) disable iff (rst)
      (serr_req && !system_error_drive_enable && !s_q.sts[PCR_STS_SSE])
      |=> !s_q.sts[PCR_STS_SSE])
   else $error("system error flag set while drive disabled");

   chk_dpe_set:
   assert property (@(posedge clk) disable iff (rst)
      ev_parity_error |=> s_q.sts[PCR_STS_DPE])
   else $error("parity detected flag not set");

   chk_settle_hold:
   assert property (@(posedge clk) disable iff (rst)
      wr_cs |=> (!pci_access_ok) [*2])
   else $error("access allowed too soon after change");

   chk_settle_free:
   assert property (@(posedge clk) disable iff (rst)
      (!wr_cs) [*2] |=> pci_access_ok)
   else $error("access held off without a recent change");

   chk_ro_write:
   assert property (@(posedge clk) disable iff (rst)
      (cpu_sel && cpu_wr && !hit_cs) |=> $stable(s_q.cmd))
   else $error("write elsewhere changed command word");

endmodule : pcr_regs

// >>> pcr_settle.sv
// Hold-off timer that marks bus access unsafe just after a register change
`timescale 1ns/10ps
module pcr_settle
   import pcr_pkg::*;
#(
   parameter int CLKS = PCR_SETTLE_CLKS
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic kick,
   output logic      ready
);

   typedef struct packed
   {
      logic [3:0] cnt;
      logic       rdy;
   } pcr_settle_t;

   localparam logic [3:0] LOAD = 4'(CLKS);

   pcr_settle_t s_q;
   pcr_settle_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (kick)
      begin
         s_d.cnt = LOAD;
      end
      else if (s_q.cnt != 4'h0)
      begin
         s_d.cnt = s_q.cnt - 4'h1;
      end
      s_d.rdy = (s_d.cnt == 4'h0);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '{cnt: 4'h0, rdy: 1'b1};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ready = s_q.rdy;

endmodule : pcr_settle

// >>> pcr_tb.sv
// Self-checking bench for the configuration header register bank
`timescale 1ns/10ps
module tb
   import pcr_pkg::*;
;
   typedef struct packed {logic [3:0] be; logic [31:0] wd; logic [15:0] cmd;} pcr_tb_row_t;

   // Arbitrary identity values
   localparam logic [15:0] MID = 16'h5E17;
   localparam logic [15:0] PID = 16'h00C9;

   localparam pcr_tb_row_t ROWS [5] = '{
      '{4'h3, 32'h0000_FFFF, 16'h0147},
      '{4'h1, 32'h0000_0000, 16'h0100},
      '{4'h2, 32'h0000_FEFF, 16'h0000},
      '{4'hF, 32'hFFFF_0002, 16'h0002},
      '{4'h1, 32'h0000_0045, 16'h0045}};

   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic        sel   = 1'b0;
   logic        wr    = 1'b0;
   logic [8:0]  addr  = 9'h000;
   logic [3:0]  be    = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [8:0]  pul   = 9'h000;
   logic        ack;
   logic [31:0] rdata;
   logic [4:0]  en;
   logic [3:0]  drv;
   logic        ok;
   logic [15:0] cmd_m;
   logic [15:0] sts_m;
   logic [31:0] rd;
   logic [4:0]  en_s;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   int          i;

   pcr_regs #(.MAKER_ID(MID), .PART_ID(PID)) dut
   (
      .clk(clk), .rst(rst), .cpu_sel(sel), .cpu_wr(wr), .cpu_addr(addr), .cpu_be(be),
      .cpu_wdata(wdata), .cpu_ack(ack), .cpu_rdata(rdata),
      .ev_sig_target_abort(pul[8]), .ev_rcv_target_abort(pul[7]),
      .ev_rcv_master_abort(pul[6]), .ev_parity_error(pul[5]), .ev_data_parity(pul[4]),
      .perr_req(pul[3]), .serr_req(pul[2]), .mem_access_req(pul[1]), .master_req(pul[0]),
      .io_space_enable(en[0]), .memory_space_enable(en[1]), .bus_master_enable(en[2]),
      .parity_check_enable(en[3]), .system_error_drive_enable(en[4]),
      .perr_drive(drv[3]), .serr_drive(drv[2]), .mem_respond(drv[1]), .master_go(drv[0]),
      .pci_access_ok(ok)
   );

   always #25 clk = ~clk;

   // Whole run is under a hundred cycles; ceiling leaves ample margin
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Entered just after an edge; returns at the edge after the answer
   task automatic bus(input logic w, input logic [8:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      sel   <= 1'b1;
      wr    <= w;
      addr  <= a;
      be    <= b;
      wdata <= d;
      @(posedge clk);
      sel <= 1'b0;
      pul <= 9'h000;
      #1;
      check("cpu_ack", ack, 32'h1);
      rd   = rdata;
      en_s = en;
      if (w)
         check("cpu_rdata on write", rdata, 32'h0);
      if (w && a[8:2] == PCR_OFS_CMD[8:2])
         check("access hold first", ok, 32'h0);
      @(posedge clk);
   endtask : bus

   // Hardware sets land after any same-cycle clear
   function automatic void sets(input logic [8:0] v);
      sts_m = sts_m | {v[5], v[2] & cmd_m[8], v[6], v[7], v[8], 2'b00, v[4] & cmd_m[6], 8'h00};
   endfunction : sets

   task automatic wcmd(input logic [3:0] b, input logic [31:0] d, input logic [15:0] c);
      bus(1'b1, PCR_OFS_CMD, b, d);
      cmd_m = c;
      sts_m = sts_m & ~(d[31:16] & PCR_STS_FLAGS & {{8{b[3]}}, {8{b[2]}}});
   endtask : wcmd

   task automatic rchk(input string name);
      bus(1'b0, PCR_OFS_CMD, 4'hF, 32'h0);
      check(name, rd, {sts_m, cmd_m});
      check("enables", en_s, {cmd_m[8], cmd_m[6], cmd_m[2:0]});
   endtask : rchk

   task automatic pulse(input logic [8:0] v);
      pul <= v;
      @(posedge clk);
      pul <= 9'h000;
      #1;
      check("gated lines", drv,
            {v[3] & cmd_m[6], v[2] & cmd_m[8], v[1] & cmd_m[1], v[0] & cmd_m[2]});
      sets(v);
      @(posedge clk);
   endtask : pulse

   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   initial
   begin
      cmd_m = PCR_CMD_RST;
      sts_m = PCR_STS_CONST;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, PCR_OFS_ID, 4'hF, 32'h0);
      check("identifiers", rd, {PID, MID});
      bus(1'b0, PCR_OFS_PART, 4'hF, 32'h0);
      check("identifiers upper half", rd, {PID, MID});
      bus(1'b1, PCR_OFS_ID, 4'hF, 32'hFFFF_FFFF);
      bus(1'b0, PCR_OFS_ID, 4'hF, 32'h0);
      check("identifiers after write", rd, {PID, MID});
      bus(1'b0, 9'h1FC, 4'hF, 32'h0);
      check("unmapped read", rd, 32'h0);
      rchk("reset word");
      // Data parity event too, while its enable is still off
      pulse(9'h01F);
      for (i = 0; i < 5; i++)
      begin
         wcmd(ROWS[i].be, ROWS[i].wd, ROWS[i].cmd);
         rchk("command row");
      end
      pulse(9'h01F);
      rchk("parity reported");
      wcmd(4'h3, 32'h0000_FFFF, 16'h0147);
      #1;
      check("access hold second", ok, 32'h0);
      @(posedge clk);
      #1;
      check("access ok", ok, 32'h1);
      // Bus traffic only once the two settle clocks have passed
      @(posedge clk);
      pulse(9'h1FF);
      rchk("all flags");
      wcmd(4'h8, 32'h8000_0000, 16'h0147);
      rchk("clear top flag");
      wcmd(4'h4, 32'hFFFF_FFFF, 16'h0147);
      rchk("constant lane write");
      wcmd(4'h8, 32'h7900_0000, 16'h0147);
      rchk("flags cleared");
      pul <= 9'h040;
      wcmd(4'h8, 32'h2000_0000, 16'h0147);
      sets(9'h040);
      rchk("set beats clear");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("outputs in reset", {ack, en, drv, ok}, 32'h001);
      @(posedge clk);
      rst <= 1'b0;
      cmd_m = PCR_CMD_RST;
      sts_m = PCR_STS_CONST;
      @(posedge clk);
      rchk("word after reset");
      complete_run();
   end
endmodule : tb
